/* File: verilog/pmbcs_top.sv */
// loop mode control, settle detection and base clock select with AXI4-Lite registers
//
// Contract
// - acquisition mode shows tracking indicator cleared
// - acquisition filter unless tracking or track bit
// - automatic mode: detector switches filter mode itself
// - automatic: track bit read-only, follows tolerance
// - automatic: settled indicator read-only, follows tolerance
// - automatic: settle toggle raises enabled interrupt
// - manual: written track bit chooses filter mode
// - manual: settled indicator and interrupts disabled
// - feedback multiplier zero acts as one
// - range zero: loop off, crystal forced
// - switch waits three edges, output held static
// - selected clock divided by two
// - oscillator select refused while loop off
// - loop off refused while oscillator selected
// - loop on and select need separate writes
// - settle toggle sets flag, control read clears
// - manual track value kept through automatic mode
// - reset and stop clear base source select
// - reset sets loop power on
`timescale 1ns/1ps
module pmbcs_top
  import pmbcs_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // AXI4-Lite slave
  input  wire logic [PMBCS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [PMBCS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // analogue lock detector comparator levels
  input  wire logic                    inLockTol,
  input  wire logic                    outUnlockTol,
  input  wire logic                    inTrackTol,
  input  wire logic                    outUntrackTol,
  // stop instruction executed, same clock domain
  input  wire logic                    stopExec,
  // clocks to select between, sampled
  input  wire logic                    crystal_clock,
  input  wire logic                    oscillator_clock,
  // outputs to the analogue loop and system
  output logic                         loopEnable,
  output logic                         filterTrackMode,
  output logic [3:0]                   feedbackMult,
  output logic [3:0]                   rangeMult,
  output logic                         settleIrq,
  output logic                         base_clock_out
);

  // synchronised detector levels
  logic       lk1_q, lk2_q, ul1_q, ul2_q, tr1_q, tr2_q, ut1_q, ut2_q;

  // AXI state
  logic       awHeld_q, awHeld_d;
  logic       wHeld_q, wHeld_d;
  logic [PMBCS_ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [7:0] wByte_q, wByte_d;
  logic       wLane_q, wLane_d;
  logic       bValid_q, bValid_d;
  logic [1:0] bResp_q, bResp_d;
  logic       arReady_q, arReady_d;
  logic       rValid_q, rValid_d;
  logic [31:0] rData_q, rData_d;
  logic [1:0] rResp_q, rResp_d;
  logic       doWrite, doRead;

  // register state
  logic       ie_q, ie_d;
  logic       flag_q, flag_d;
  logic       on_q, on_d;
  logic       bss_q, bss_d;
  logic       auto_q, auto_d;
  logic       lock_q, lock_d;
  logic       autoTrack_q, autoTrack_d;
  logic       manTrack_q, manTrack_d;
  logic [7:0] prog_q, prog_d;
  logic       loopEn_q, loopEn_d;
  logic       track_q, track_d;
  logic [3:0] fb_q, fb_d;
  logic [3:0] rng_q, rng_d;
  logic       irq_q, irq_d;
  logic       rangeOk;
  logic       srcIsOsc, baseClk;

  // true when an address hits a mapped register
  function automatic logic isMapped(input logic [PMBCS_ADDR_W-1:0] a);
    isMapped = (a == PMBCS_ADDR_CTRL) || (a == PMBCS_ADDR_BW) || (a == PMBCS_ADDR_PROG);
  endfunction : isMapped

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lk1_q <= 1'b0;
      lk2_q <= 1'b0;
      ul1_q <= 1'b0;
      ul2_q <= 1'b0;
      tr1_q <= 1'b0;
      tr2_q <= 1'b0;
      ut1_q <= 1'b0;
      ut2_q <= 1'b0;
    end else begin
      lk1_q <= inLockTol;
      lk2_q <= lk1_q;
      ul1_q <= outUnlockTol;
      ul2_q <= ul1_q;
      tr1_q <= inTrackTol;
      tr2_q <= tr1_q;
      ut1_q <= outUntrackTol;
      ut2_q <= ut1_q;
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  assign doWrite = awHeld_q & wHeld_q & ~bValid_q;
  assign doRead  = s_axi_arvalid & arReady_q;

  always_comb begin
    awHeld_d  = awHeld_q;
    wHeld_d   = wHeld_q;
    awAddr_d  = awAddr_q;
    wByte_d   = wByte_q;
    wLane_d   = wLane_q;
    bValid_d  = bValid_q;
    bResp_d   = bResp_q;
    arReady_d = arReady_q;
    rValid_d  = rValid_q;
    rData_d   = rData_q;
    rResp_d   = rResp_q;
    if (s_axi_awvalid & ~awHeld_q) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~wHeld_q) begin
      wHeld_d = 1'b1;
      wByte_d = s_axi_wdata[7:0];
      wLane_d = s_axi_wstrb[0];
    end
    if (doWrite) begin
      bValid_d = 1'b1;
      bResp_d  = isMapped(awAddr_q) ? PMBCS_RESP_OKAY : PMBCS_RESP_SLVERR;
    end else if (bValid_q & s_axi_bready) begin
      // address and data slots reopen once the response is taken
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b0;
    end
    if (doRead) begin
      arReady_d = 1'b0;
      rValid_d  = 1'b1;
      rResp_d   = isMapped(s_axi_araddr) ? PMBCS_RESP_OKAY : PMBCS_RESP_SLVERR;
      rData_d   = 32'h0;
      case (s_axi_araddr)
        PMBCS_ADDR_CTRL: begin
          rData_d[PMBCS_CTRL_IE_BIT]   = ie_q;
          rData_d[PMBCS_CTRL_FLAG_BIT] = flag_q;
          rData_d[PMBCS_CTRL_ON_BIT]   = on_q;
          rData_d[PMBCS_CTRL_BSS_BIT]  = bss_q;
          rData_d[3:0]                 = PMBCS_CTRL_LOW_RD;
        end
        PMBCS_ADDR_BW: begin
          rData_d[PMBCS_BW_AUTO_BIT]  = auto_q;
          rData_d[PMBCS_BW_LOCK_BIT]  = auto_q & lock_q;
          rData_d[PMBCS_BW_TRACK_BIT] = auto_q ? autoTrack_q : manTrack_q;
        end
        PMBCS_ADDR_PROG: begin
          rData_d[7:0] = prog_q;
        end
        default: begin
          rData_d = 32'h0;
        end
      endcase
    end else if (rValid_q & s_axi_rready) begin
      rValid_d  = 1'b0;
      arReady_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awAddr_q  <= '0;
      wByte_q   <= 8'h0;
      wLane_q   <= 1'b0;
      bValid_q  <= 1'b0;
      bResp_q   <= PMBCS_RESP_OKAY;
      arReady_q <= 1'b1;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0;
      rResp_q   <= PMBCS_RESP_OKAY;
    end else begin
      awHeld_q  <= awHeld_d;
      wHeld_q   <= wHeld_d;
      awAddr_q  <= awAddr_d;
      wByte_q   <= wByte_d;
      wLane_q   <= wLane_d;
      bValid_q  <= bValid_d;
      bResp_q   <= bResp_d;
      arReady_q <= arReady_d;
      rValid_q  <= rValid_d;
      rData_q   <= rData_d;
      rResp_q   <= rResp_d;
    end
  end

  assign s_axi_awready = ~awHeld_q;
  assign s_axi_wready  = ~wHeld_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  // ---------------- control and status ----------------
  assign rangeOk = (prog_q[PMBCS_PROG_RNG_MSB:PMBCS_PROG_RNG_LSB] != PMBCS_MUL_ZERO);

  always_comb begin
    logic wrCtrl, wrBw, wrProg, rdCtrl;
    wrCtrl      = doWrite & wLane_q & (awAddr_q == PMBCS_ADDR_CTRL);
    wrBw        = doWrite & wLane_q & (awAddr_q == PMBCS_ADDR_BW);
    wrProg      = doWrite & wLane_q & (awAddr_q == PMBCS_ADDR_PROG);
    rdCtrl      = doRead & (s_axi_araddr == PMBCS_ADDR_CTRL);
    ie_d        = ie_q;
    on_d        = on_q;
    bss_d       = bss_q;
    auto_d      = auto_q;
    manTrack_d  = manTrack_q;
    prog_d      = prog_q;
    lock_d      = lock_q;
    autoTrack_d = autoTrack_q;
    if (wrCtrl) begin
      if (auto_q) begin
        ie_d = wByte_q[PMBCS_CTRL_IE_BIT];
      end
      // decisions use the values before this write
      on_d  = wByte_q[PMBCS_CTRL_ON_BIT] | bss_q | srcIsOsc;
      bss_d = wByte_q[PMBCS_CTRL_BSS_BIT] & on_q & rangeOk;
    end
    if (wrBw) begin
      auto_d = wByte_q[PMBCS_BW_AUTO_BIT];
      if (!auto_q) begin
        manTrack_d = wByte_q[PMBCS_BW_TRACK_BIT];
      end
    end
    if (wrProg) begin
      prog_d = wByte_q;
    end
    if (!rangeOk || stopExec) begin
      bss_d = 1'b0;
    end
    if (!auto_q) begin
      ie_d        = 1'b0;
      lock_d      = 1'b0;
      autoTrack_d = 1'b0;
    end else begin
      // hysteresis between entry and exit tolerances
      if (lk2_q) begin
        lock_d = 1'b1;
      end else if (ul2_q) begin
        lock_d = 1'b0;
      end
      if (tr2_q) begin
        autoTrack_d = 1'b1;
      end else if (ut2_q) begin
        autoTrack_d = 1'b0;
      end
    end
    // toggle sets, control read clears, set wins
    if (!auto_q) begin
      flag_d = 1'b0;
    end else if (lock_d != lock_q) begin
      flag_d = 1'b1;
    end else if (rdCtrl) begin
      flag_d = 1'b0;
    end else begin
      flag_d = flag_q;
    end
    loopEn_d = on_d & (prog_d[PMBCS_PROG_RNG_MSB:PMBCS_PROG_RNG_LSB] != PMBCS_MUL_ZERO);
    track_d  = auto_d ? autoTrack_d : manTrack_d;
    fb_d     = (prog_d[PMBCS_PROG_FB_MSB:PMBCS_PROG_FB_LSB] == PMBCS_MUL_ZERO)
             ? PMBCS_MUL_ONE : prog_d[PMBCS_PROG_FB_MSB:PMBCS_PROG_FB_LSB];
    rng_d    = prog_d[PMBCS_PROG_RNG_MSB:PMBCS_PROG_RNG_LSB];
    irq_d    = auto_d & ie_d & flag_d;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ie_q        <= PMBCS_RST_IE;
      flag_q      <= 1'b0;
      on_q        <= PMBCS_RST_ON;
      bss_q       <= PMBCS_RST_BSS;
      auto_q      <= PMBCS_RST_AUTO;
      lock_q      <= 1'b0;
      autoTrack_q <= PMBCS_RST_TRACK;
      manTrack_q  <= PMBCS_RST_TRACK;
      prog_q      <= PMBCS_RST_PROG;
      loopEn_q    <= PMBCS_RST_ON;
      track_q     <= PMBCS_RST_TRACK;
      fb_q        <= PMBCS_RST_PROG[PMBCS_PROG_FB_MSB:PMBCS_PROG_FB_LSB];
      rng_q       <= PMBCS_RST_PROG[PMBCS_PROG_RNG_MSB:PMBCS_PROG_RNG_LSB];
      irq_q       <= 1'b0;
    end else begin
      ie_q        <= ie_d;
      flag_q      <= flag_d;
      on_q        <= on_d;
      bss_q       <= bss_d;
      auto_q      <= auto_d;
      lock_q      <= lock_d;
      autoTrack_q <= autoTrack_d;
      manTrack_q  <= manTrack_d;
      prog_q      <= prog_d;
      loopEn_q    <= loopEn_d;
      track_q     <= track_d;
      fb_q        <= fb_d;
      rng_q       <= rng_d;
      irq_q       <= irq_d;
    end
  end

  assign loopEnable      = loopEn_q;
  assign filterTrackMode = track_q;
  assign feedbackMult    = fb_q;
  assign rangeMult       = rng_q;
  assign settleIrq       = irq_q;
  assign base_clock_out  = baseClk;

  // ---------------- base clock selector ----------------
  pmbcs_clock_select u_clock_select (
    .sys_clk          (sys_clk),
    .rst              (rst),
    .crystal_clock    (crystal_clock),
    .oscillator_clock (oscillator_clock),
    .selOsc           (bss_q & rangeOk),
    .base_clock_out   (baseClk),
    .srcIsOsc         (srcIsOsc),
    .switching        ()
  );

endmodule : pmbcs_top

/* File: include/pmbcs_pkg.sv */
// constants shared by the loop mode and base clock select block
package pmbcs_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  PMBCS_IDX_CTRL      = 8'h1c;
  localparam logic [7:0]  PMBCS_IDX_BW        = 8'h1d;
  localparam logic [7:0]  PMBCS_IDX_PROG      = 8'h1e;
  localparam logic [11:0] PMBCS_ADDR_CTRL     = 12'h070;
  localparam logic [11:0] PMBCS_ADDR_BW       = 12'h074;
  localparam logic [11:0] PMBCS_ADDR_PROG     = 12'h078;
  localparam int          PMBCS_ADDR_W        = 12;

  // loop_control_register fields
  localparam int          PMBCS_CTRL_IE_BIT   = 7;
  localparam int          PMBCS_CTRL_FLAG_BIT = 6;
  localparam int          PMBCS_CTRL_ON_BIT   = 5;
  localparam int          PMBCS_CTRL_BSS_BIT  = 4;
  localparam logic [3:0]  PMBCS_CTRL_LOW_RD   = 4'hf;

  // bandwidth control register fields
  localparam int          PMBCS_BW_AUTO_BIT   = 7;
  localparam int          PMBCS_BW_LOCK_BIT   = 6;
  localparam int          PMBCS_BW_TRACK_BIT  = 5;
  localparam int          PMBCS_BW_XLOSS_BIT  = 4;

  // loop_program_register fields
  localparam int          PMBCS_PROG_FB_MSB   = 7;
  localparam int          PMBCS_PROG_FB_LSB   = 4;
  localparam int          PMBCS_PROG_RNG_MSB  = 3;
  localparam int          PMBCS_PROG_RNG_LSB  = 0;

  // reset values
  localparam logic        PMBCS_RST_IE        = 1'b0;
  localparam logic        PMBCS_RST_ON        = 1'b1;
  localparam logic        PMBCS_RST_BSS       = 1'b0;
  localparam logic        PMBCS_RST_AUTO      = 1'b0;
  localparam logic        PMBCS_RST_TRACK     = 1'b0;
  localparam logic [7:0]  PMBCS_RST_PROG      = 8'h11;

  // multiplier exceptions
  localparam logic [3:0]  PMBCS_MUL_ZERO      = 4'h0;
  localparam logic [3:0]  PMBCS_MUL_ONE       = 4'h1;

  // source switch: edges of each input clock waited during a switch
  localparam logic [1:0]  PMBCS_SWITCH_EDGES  = 2'h3;

  // AXI responses
  localparam logic [1:0]  PMBCS_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  PMBCS_RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    PMBCS_CS_RUN = 2'b00,
    PMBCS_CS_OLD = 2'b01,
    PMBCS_CS_NEW = 2'b10
  } pmbcs_cs_state_t;

endpackage : pmbcs_pkg

/* File: verilog/pmbcs_clock_select.sv */
// glitch-free base clock selector with divide by two
`timescale 1ns/1ps
module pmbcs_clock_select
  import pmbcs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic crystal_clock,
  input  wire logic oscillator_clock,
  input  wire logic selOsc,
  output logic      base_clock_out,
  output logic      srcIsOsc,
  output logic      switching
);

  logic            xS1_q, xS2_q, xS3_q;
  logic            vS1_q, vS2_q, vS3_q;
  logic            xRise, vRise, curRise, oldRise, newRise;
  pmbcs_cs_state_t state_q, state_d;
  logic [1:0]      edgeCnt_q, edgeCnt_d;
  logic            cur_q, cur_d;
  logic            div_q, div_d;

  // two-flop synchronisers, third stage only for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xS1_q <= 1'b0;
      xS2_q <= 1'b0;
      xS3_q <= 1'b0;
      vS1_q <= 1'b0;
      vS2_q <= 1'b0;
      vS3_q <= 1'b0;
    end else begin
      xS1_q <= crystal_clock;
      xS2_q <= xS1_q;
      xS3_q <= xS2_q;
      vS1_q <= oscillator_clock;
      vS2_q <= vS1_q;
      vS3_q <= vS2_q;
    end
  end

  assign xRise   = xS2_q & ~xS3_q;
  assign vRise   = vS2_q & ~vS3_q;
  assign curRise = cur_q ? vRise : xRise;
  assign oldRise = curRise;
  assign newRise = cur_q ? xRise : vRise;

  always_comb begin
    state_d   = state_q;
    edgeCnt_d = edgeCnt_q;
    cur_d     = cur_q;
    div_d     = div_q;
    case (state_q)
      PMBCS_CS_RUN: begin
        if (selOsc != cur_q) begin
          state_d   = PMBCS_CS_OLD;
          edgeCnt_d = 2'h0;
        end else if (curRise) begin
          div_d = ~div_q;
        end
      end
      PMBCS_CS_OLD: begin
        // old clock gated off, output held static
        if (selOsc == cur_q) begin
          state_d = PMBCS_CS_RUN;
        end else if (oldRise) begin
          if (edgeCnt_q == PMBCS_SWITCH_EDGES - 2'h1) begin
            state_d   = PMBCS_CS_NEW;
            edgeCnt_d = 2'h0;
          end else begin
            edgeCnt_d = edgeCnt_q + 2'h1;
          end
        end
      end
      PMBCS_CS_NEW: begin
        if (selOsc == cur_q) begin
          state_d = PMBCS_CS_RUN;
        end else if (newRise) begin
          if (edgeCnt_q == PMBCS_SWITCH_EDGES - 2'h1) begin
            state_d = PMBCS_CS_RUN;
            cur_d   = ~cur_q;
          end else begin
            edgeCnt_d = edgeCnt_q + 2'h1;
          end
        end
      end
      default: begin
        state_d = PMBCS_CS_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= PMBCS_CS_RUN;
      edgeCnt_q <= 2'h0;
      cur_q     <= 1'b0;
      div_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      edgeCnt_q <= edgeCnt_d;
      cur_q     <= cur_d;
      div_q     <= div_d;
    end
  end

  assign base_clock_out = div_q;
  assign srcIsOsc       = cur_q;
  assign switching      = (state_q != PMBCS_CS_RUN);

endmodule : pmbcs_clock_select

/* File: dv/pmbcs_checker_sva.sv */
// port assertions for the loop mode and base clock select block
`timescale 1ns/1ps
module pmbcs_checker
  import pmbcs_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        loopEnable,
  input wire logic        filterTrackMode,
  input wire logic [3:0]  feedbackMult,
  input wire logic [3:0]  rangeMult,
  input wire logic        settleIrq,
  input wire logic        base_clock_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       baseQ, baseD;
  logic [3:0] gapQ, gapD;
  // cycles since the base clock last moved, saturating
  always_comb begin
    baseD = base_clock_out;
    gapD  = (base_clock_out != baseQ) ? 4'h0 : ((gapQ == 4'hf) ? gapQ : gapQ + 4'h1);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      baseQ <= 1'b0;
      gapQ  <= 4'hf;
    end else begin
      baseQ <= baseD;
      gapQ  <= gapD;
    end
  end
  reset_values_a: assert property ($fell(rst) |-> loopEnable && !filterTrackMode
    && feedbackMult == 4'h1 && rangeMult == 4'h1) else $error("bad values after reset");
  feedback_nonzero_a: assert property (feedbackMult != 4'h0)
    else $error("feedback multiplier shows zero");
  range_off_a: assert property (rangeMult == 4'h0 |-> !loopEnable)
    else $error("loop enabled with zero range");
  irq_fall_a: assert property ($fell(settleIrq) |-> s_axi_rvalid || $past(s_axi_rvalid)
    || $past(s_axi_rvalid, 2) || s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt dropped without bus access");
  half_period_a: assert property (base_clock_out != baseQ |-> gapQ >= 4'h3)
    else $error("base clock runt pulse");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits not zero");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  cover property ($rose(settleIrq));
  cover property ($fell(loopEnable));
  cover property (base_clock_out != baseQ && gapQ == 4'h5);
endmodule : pmbcs_checker

/* File: dv/pmbcs_loop_model.sv */
// far side model: crystal and oscillator clocks plus lock detector levels
`timescale 1ns/1ps
module pmbcs_loop_model (
  input  wire logic loopEnable,
  input  wire logic wantLock,
  input  wire logic wantTrack,
  output logic      crystal_clock,
  output logic      oscillator_clock,
  output logic      inLockTol,
  output logic      outUnlockTol,
  output logic      inTrackTol,
  output logic      outUntrackTol
);
  initial begin
    crystal_clock = 1'b0;
    forever #115 crystal_clock = ~crystal_clock;
  end
  // oscillator stands still while the loop is off
  initial begin
    oscillator_clock = 1'b0;
    forever begin
      #85;
      if (loopEnable === 1'b1) oscillator_clock = ~oscillator_clock;
    end
  end
  always_comb begin
    inLockTol     = (loopEnable === 1'b1) && wantLock;
    outUnlockTol  = !inLockTol;
    inTrackTol    = (loopEnable === 1'b1) && wantTrack;
    outUntrackTol = !inTrackTol;
  end
endmodule : pmbcs_loop_model

/* File: dv/testbench.sv */
// self-checking bench for the loop mode and base clock select block
`timescale 1ns/1ps
module testbench;
  import pmbcs_pkg::*;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0]  s_axi_wstrb, feedbackMult, rangeMult;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]  rdByte, p;
  logic        sys_clk, rst, stopExec, wantLock, wantTrack, basePrev;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        inLockTol, outUnlockTol, inTrackTol, outUntrackTol, crystal_clock;
  logic        oscillator_clock, loopEnable, filterTrackMode, settleIrq, base_clock_out;
  int          failCount, nChecks;
  int          edgeCnt = 0;
  logic [7:0]  corners [4] = '{8'h00, 8'h0f, 8'hf0, 8'h01};

  pmbcs_top DUT (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .inLockTol(inLockTol), .outUnlockTol(outUnlockTol),
    .inTrackTol(inTrackTol), .outUntrackTol(outUntrackTol), .stopExec(stopExec),
    .crystal_clock(crystal_clock), .oscillator_clock(oscillator_clock),
    .loopEnable(loopEnable), .filterTrackMode(filterTrackMode), .feedbackMult(feedbackMult),
    .rangeMult(rangeMult), .settleIrq(settleIrq), .base_clock_out(base_clock_out));
  pmbcs_loop_model modelInst (.loopEnable(loopEnable), .wantLock(wantLock),
    .wantTrack(wantTrack), .crystal_clock(crystal_clock), .oscillator_clock(oscillator_clock),
    .inLockTol(inLockTol), .outUnlockTol(outUnlockTol), .inTrackTol(inTrackTol),
    .outUntrackTol(outUntrackTol));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (base_clock_out !== basePrev) edgeCnt <= edgeCnt + 1;
    basePrev <= base_clock_out;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [3:0] expFb(input logic [7:0] v);
    return (v[7:4] == 4'h0) ? 4'h1 : v[7:4];
  endfunction : expFb
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : w
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge sys_clk);
      if (!awDone && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    rdByte = s_axi_rdata[7:0];
    resp = s_axi_rresp;
  endtask : rd
  task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk("register", rdByte, e);
  endtask : rdChk
  task automatic measure(input int lo, input int hi);
    int c0;
    c0 = edgeCnt;
    w(400);
    chk("base toggles", (edgeCnt - c0 >= lo) && (edgeCnt - c0 <= hi), 1'b1);
  endtask : measure
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : printVerdict

  initial begin
    repeat (20000) @(posedge sys_clk);
    failCount++;
    printVerdict();
  end

  initial begin
    {rst, s_axi_bready, s_axi_rready} = 3'b111;
    {stopExec, wantLock, wantTrack, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    seed = 32'h36fc;
    failCount = 0;
    nChecks = 0;
    w(2);
    rst <= 1'b0;
    w(1);
    rdChk(PMBCS_ADDR_CTRL, 8'h2f);
    rdChk(PMBCS_ADDR_BW, 8'h00);
    rdChk(PMBCS_ADDR_PROG, 8'h11);
    chk("loopEnable", loopEnable, 1'b1);
    measure(42, 45);
    w(20);
    wr(PMBCS_ADDR_BW, 8'h20);
    wantLock <= 1'b1;
    w(8);
    chk("track", filterTrackMode, 1'b1);
    rdChk(PMBCS_ADDR_BW, 8'h20);
    wr(PMBCS_ADDR_CTRL, 8'ha0);
    rdChk(PMBCS_ADDR_CTRL, 8'h2f);
    chk("irq", settleIrq, 1'b0);
    wr(PMBCS_ADDR_BW, 8'ha0);
    w(8);
    rd(PMBCS_ADDR_CTRL);
    wr(PMBCS_ADDR_CTRL, 8'ha0);
    wantLock <= 1'b0;
    w(8);
    chk("irq", settleIrq, 1'b1);
    rdChk(PMBCS_ADDR_CTRL, 8'hef);
    w(2);
    chk("irq", settleIrq, 1'b0);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wantLock <= seed[0];
      wantTrack <= seed[1];
      w(8);
      rdChk(PMBCS_ADDR_BW, {2'b11 & {1'b1, seed[0]}, seed[1], 5'h0});
      chk("track", filterTrackMode, seed[1]);
    end
    wr(PMBCS_ADDR_BW, 8'h00);
    w(2);
    rdChk(PMBCS_ADDR_BW, 8'h20);
    rdChk(PMBCS_ADDR_CTRL, 8'h2f);
    chk("irq", settleIrq, 1'b0);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      p = (i < 4) ? corners[i] : seed[7:0];
      wr(PMBCS_ADDR_PROG, p);
      w(2);
      chk("feedback", feedbackMult, expFb(p));
      chk("range", rangeMult, p[3:0]);
      chk("loopEnable", loopEnable, p[3:0] != 4'h0);
    end
    wr(PMBCS_ADDR_PROG, 8'h11);
    wr(PMBCS_ADDR_CTRL, 8'h00);
    rdChk(PMBCS_ADDR_CTRL, 8'h0f);
    wr(PMBCS_ADDR_CTRL, 8'h10);
    rdChk(PMBCS_ADDR_CTRL, 8'h0f);
    wr(PMBCS_ADDR_BW, 8'h00);
    wr(PMBCS_ADDR_CTRL, 8'h30);
    rdChk(PMBCS_ADDR_CTRL, 8'h2f);
    w(20);
    wr(PMBCS_ADDR_BW, 8'h20);
    w(20);
    wr(PMBCS_ADDR_CTRL, 8'h30);
    rdChk(PMBCS_ADDR_CTRL, 8'h3f);
    w(60);
    measure(57, 60);
    wr(PMBCS_ADDR_CTRL, 8'h10);
    rdChk(PMBCS_ADDR_CTRL, 8'h3f);
    stopExec <= 1'b1;
    w(1);
    stopExec <= 1'b0;
    rdChk(PMBCS_ADDR_CTRL, 8'h2f);
    w(60);
    measure(42, 45);
    wr(PMBCS_ADDR_CTRL, 8'h30);
    wr(PMBCS_ADDR_PROG, 8'h10);
    w(2);
    chk("loopEnable", loopEnable, 1'b0);
    rdChk(PMBCS_ADDR_CTRL, 8'h2f);
    measure(42, 45);
    wr(12'h07c, 8'h55);
    chk("bresp", resp, PMBCS_RESP_SLVERR);
    rd(12'h07c);
    chk("rresp", resp, PMBCS_RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(PMBCS_ADDR_PROG, 8'h55);
    s_axi_wstrb <= 4'h1;
    rdChk(PMBCS_ADDR_PROG, 8'h10);
    printVerdict();
  end
endmodule : testbench

bind pmbcs_top pmbcs_checker checkerInst (.sys_clk(sys_clk), .rst(rst),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .loopEnable(loopEnable),
  .filterTrackMode(filterTrackMode), .feedbackMult(feedbackMult), .rangeMult(rangeMult),
  .settleIrq(settleIrq), .base_clock_out(base_clock_out));
